// >>> bench/pom_array_props.sv
// Bus and pin assertions for the macrocell array
module pom_array_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [11:0] adr_i,
  input wire logic        we_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic [9:0]  io_o,
  input wire logic [9:0]  io_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic req = cyc_i && stb_i && !ack_o;
  ack_take_a: assert property (req |=> ack_o) else $error("no ack after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  ack_cause_a: assert property (!req |=> !ack_o) else $error("ack without request");
  dat_hold_a: assert property (!ack_o ##1 !ack_o |-> $stable(dat_o)) else $error("read data moved");
  rst_quiet_a: assert property ($fell(rst_i) |-> io_oe_o == 10'h0 && ack_o == 1'b0) else $error("reset state");
  state_width_a: assert property (ack_o && !$past(we_i) && $past(adr_i) == 12'h000
    |-> dat_o[31:10] == 22'h0) else $error("state bits above ten cells");
  pins_width_a: assert property (ack_o && !$past(we_i) && $past(adr_i) == 12'h008
    |-> dat_o[15:10] == 6'h0 && dat_o[31:24] == 8'h0) else $error("pins spare bits");
  unmapped_zero_a: assert property (ack_o && !$past(we_i) && $past(adr_i) >= 12'h700
    |-> dat_o == 32'h0) else $error("unmapped read not zero");
  cover property (ack_o && we_i);
  cover property (io_oe_o[2] && io_o[2]);
  cover property ($rose(io_o[0]));
endmodule

// >>> bench/pom_array_tb_top.sv
// Self-checking bench for the macrocell array
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module pom_array_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, pclk_i, ack_o;
  logic [11:0] adr_i = 12'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd_v;
  logic [7:0]  in_i = 8'h0;
  logic [9:0]  io_i, io_o, io_oe_o;
  int          fail_count = 0, n_compared = 0, cyc_n = 0;
  always #25 clk_i = ~clk_i;
  pom_array pom_array_inst (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .sel_i(4'hf), .we_i, .cyc_i,
    .stb_i, .ack_o, .pclk_i, .in_i, .io_i, .io_o, .io_oe_o);
  pom_board pom_board_inst (.clk_i, .io_o_i(io_o), .oe_i(io_oe_o), .io_i_o(io_i), .pclk_o(pclk_i));
  task automatic tally_and_finish;
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd_v = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK($sformatf("reg %h", a), e, rd_v)
  endtask
  task automatic term(input int t, input logic [17:0] tm, input logic [17:0] cm);
    bus(1'b1, 12'h400 + 12'(8 * t), {14'h0, tm});
    bus(1'b1, 12'h404 + 12'(8 * t), {14'h0, cm});
    repeat (5) @(posedge clk_i);
  endtask
  task automatic cfg(input int c, input logic [3:0] v);
    bus(1'b1, 12'h040 + 12'(4 * c), {28'h0, v});
    repeat (5) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(12'h040, 32'h1);
    rd(12'h000, 32'h0);
    bus(1'b1, 12'h004, 32'h2a5);
    // Write to the read-only state word must not disturb the flops
    bus(1'b1, 12'h000, 32'h0);
    rd(12'h000, 32'h2a5);
    rd(12'h7f0, 32'h0);
    term(20, 18'h1, 18'h0);
    in_i <= 8'h1;
    cfg(2, 4'h7);
    `CHK("pin 2 drive", 2'b11, {io_oe_o[2], io_o[2]})
    cfg(2, 4'h6);
    `CHK("pin 2 inverted", 1'b0, io_o[2])
    cfg(2, 4'hb);
    `CHK("pin 2 released", 1'b0, io_oe_o[2])
    term(28, 18'h400, 18'h0);
    cfg(3, 4'h7);
    `CHK("pin 3 from pin 2", 1'b1, io_o[3])
    bus(1'b1, 12'h004, 32'h3ff);
    term(94, 18'h0, 18'h0);
    rd(12'h000, 32'h0);
    term(94, 18'h2, 18'h0);
    term(95, 18'h0, 18'h0);
    rd(12'h000, 32'h0);
    pom_board_inst.pulse();
    rd(12'h000, 32'h3ff);
    term(84, 18'h0, 18'h0);
    `CHK("pin 0 registered", 2'b11, {io_oe_o[0], io_o[0]})
    cfg(0, 4'h0);
    `CHK("pin 0 inverted", 1'b0, io_o[0])
    term(94, 18'h0, 18'h0);
    pom_board_inst.pulse();
    rd(12'h000, 32'h0);
    // Pin 0 low but its inverted flop output high: cell 4 must see the flop
    cfg(0, 4'h1);
    term(36, 18'h100, 18'h0);
    cfg(4, 4'h7);
    `CHK("pin 4 from flop 0", 1'b1, io_o[4])
    tally_and_finish();
  end
endmodule
bind pom_array pom_array_props pom_array_props_inst (.clk_i, .rst_i, .adr_i, .we_i, .cyc_i, .stb_i,
  .ack_o, .dat_o, .io_o, .io_oe_o);

// >>> bench/pom_board.sv
// Board model: pin pull-ups and device clock pulses
module pom_board (
  input  wire logic       clk_i,
  input  wire logic [9:0] io_o_i,
  input  wire logic [9:0] oe_i,
  output logic      [9:0] io_i_o,
  output logic            pclk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released pins float high through the pull-ups
  assign io_i_o = (io_o_i & oe_i) | ~oe_i;
  initial pclk_o = 1'b0;
  // Three cycles high and four low after, so the two-flop sync cannot miss it
  task automatic pulse;
    repeat (3) @(posedge clk_i);
    pclk_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    pclk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// >>> logic/pom_array.sv
// Ten-cell programmable AND-OR array with output macrocells and a Wishbone configuration port
module pom_array #(
  parameter int NUM_IN = pom_pkg::NUM_IN
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic [pom_pkg::ADR_W-1:0]      adr_i,
  input  wire logic [31:0]                    dat_i,
  output logic      [31:0]                    dat_o,
  input  wire logic [3:0]                     sel_i,
  input  wire logic                           we_i,
  input  wire logic                           cyc_i,
  input  wire logic                           stb_i,
  output logic                                ack_o,
  input  wire logic                           pclk_i,
  input  wire logic [NUM_IN-1:0]              in_i,
  input  wire logic [pom_pkg::NUM_CELL-1:0]   io_i,
  output logic      [pom_pkg::NUM_CELL-1:0]   io_o,
  output logic      [pom_pkg::NUM_CELL-1:0]   io_oe_o
);
  localparam int NC   = pom_pkg::NUM_CELL;
  localparam int NT   = pom_pkg::NUM_TERMS;
  localparam int NLIT = NC + NUM_IN;

  function automatic int term_base(input int c);
    return (c < pom_pkg::WIDE_CELLS) ? c * pom_pkg::WIDE_TERMS
         : pom_pkg::WIDE_CELLS * pom_pkg::WIDE_TERMS + (c - pom_pkg::WIDE_CELLS) * pom_pkg::NARROW_TERMS;
  endfunction

  function automatic int term_cnt(input int c);
    return (c < pom_pkg::WIDE_CELLS) ? pom_pkg::WIDE_TERMS : pom_pkg::NARROW_TERMS;
  endfunction

  // Mask bit set means the literal is connected; an empty term is true
  function automatic logic term_on(input logic [NLIT-1:0] tm, input logic [NLIT-1:0] cm,
                                   input logic [NLIT-1:0] l);
    return (&(~tm | l)) & (&(~cm | ~l));
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // Pin synchronisers; the edge detector reads only the second stage onward
  logic [NUM_IN-1:0] in_m_q, in_s_q;
  logic [NC-1:0]     io_m_q, io_s_q;
  logic [2:0]        pclk_q;

  // Dedicated inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_m_q <= '0;
      in_s_q <= '0;
    end else begin
      in_m_q <= in_i;
      in_s_q <= in_m_q;
    end
  end

  // I/O pin levels; idle high like a released pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_m_q <= '1;
      io_s_q <= '1;
    end else begin
      io_m_q <= io_i;
      io_s_q <= io_m_q;
    end
  end

  // Held high in reset so a pin already high at release gives no false edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pclk_q <= 3'h7;
    end else begin
      pclk_q <= {pclk_q[1:0], pclk_i};
    end
  end

  wire pclk_rise = pclk_q[1] & ~pclk_q[2];

  // Configuration store
  logic [pom_pkg::CFG_W-1:0] cfg_q [NC];
  logic [NLIT-1:0]           tmask_q [NT];
  logic [NLIT-1:0]           cmask_q [NT];
  logic [NC-1:0]             q_q;

  wire [NC-1:0] mode_comb;
  wire [NC-1:0] pol_true;
  wire [NC-1:0] fb;
  wire [NC-1:0] q_eff;
  wire [NLIT-1:0] lit = {fb, in_s_q};

  logic [NT-1:0] pt;
  logic [NC-1:0] sum;

  always_comb begin
    for (int t = 0; t < NT; t++) begin
      pt[t] = term_on(tmask_q[t], cmask_q[t], lit);
    end
  end

  always_comb begin
    for (int c = 0; c < NC; c++) begin
      sum[c] = 1'b0;
      for (int k = 0; k < pom_pkg::WIDE_TERMS; k++) begin
        if (k < term_cnt(c)) begin
          sum[c] = sum[c] | pt[term_base(c) + k];
        end
      end
    end
  end

  wire ar = pt[pom_pkg::AR_IDX];
  wire sp = pt[pom_pkg::SP_IDX];

  // Clear masks the stored state at once, ahead of the next clock
  assign q_eff = q_q & ~{NC{ar}};

  logic [NC-1:0] val_d, oe_d;

  for (genvar c = 0; c < NC; c++) begin : g_cell
    wire [1:0] oe_sel = cfg_q[c][pom_pkg::CFG_OE_LSB +: 2];
    assign mode_comb[c] = (cfg_q[c][pom_pkg::CFG_MODE_BIT] == pom_pkg::MODE_COMB);
    assign pol_true[c]  = (cfg_q[c][pom_pkg::CFG_POL_BIT] == pom_pkg::POL_TRUE);
    // Registered feedback uses the raw flip-flop so the clear term cannot form a loop
    assign fb[c] = mode_comb[c] ? io_s_q[c] : ~q_q[c];
    wire raw = mode_comb[c] ? sum[c] : q_eff[c];
    wire oe_term = pt[pom_pkg::OE_BASE + c];
    wire oe_comb = (oe_sel == pom_pkg::OE_ON) ? 1'b1
                 : (oe_sel == pom_pkg::OE_OFF) ? 1'b0 : oe_term;
    assign val_d[c] = pol_true[c] ? raw : ~raw;
    assign oe_d[c]  = mode_comb[c] ? oe_comb : oe_term;
  end

  // Pins are registered; one clk_i cycle behind the array
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_o <= '0;
    end else begin
      io_o <= val_d;
    end
  end

  // Enables stay off through reset so no pin is driven early
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_oe_o <= '0;
    end else begin
      io_oe_o <= oe_d;
    end
  end

  // Register bus decode
  logic ack_q;
  wire req     = cyc_i & stb_i & ~ack_q;
  wire wr      = req & we_i;
  wire [3:0] cfg_idx  = adr_i[5:2];
  wire [6:0] term_idx = adr_i[9:3];
  wire hit_state = (adr_i == pom_pkg::ADR_STATE);
  wire hit_pre   = (adr_i == pom_pkg::ADR_PRELOAD);
  wire hit_pins  = (adr_i == pom_pkg::ADR_PINS);
  wire hit_cfg   = (adr_i[11:6] == pom_pkg::CFG_REGION) && (int'(cfg_idx) < NC);
  wire hit_term  = (adr_i[11:10] == pom_pkg::TERM_REGION) && (int'(term_idx) < NT);
  wire term_cmp  = adr_i[2];

  // Write strobes, one per storage group
  wire wr_cfg   = wr & hit_cfg;
  wire wr_tmask = wr & hit_term & ~term_cmp;
  wire wr_cmask = wr & hit_term & term_cmp;
  wire wr_pre   = wr & hit_pre;

  // Read fields, zero-extended; index reads only used when their hit is set
  wire [31:0] rd_state = {{(32-NC){1'b0}}, q_q};
  wire [31:0] rd_pins  = (32'(in_s_q) << pom_pkg::PINS_IN_LSB) | 32'(io_s_q);
  wire [31:0] rd_cfg   = hit_cfg ? 32'(cfg_q[cfg_idx]) : 32'h0;
  wire [31:0] rd_tm    = hit_term ? 32'(tmask_q[term_idx]) : 32'h0;
  wire [31:0] rd_cm    = hit_term ? 32'(cmask_q[term_idx]) : 32'h0;
  wire [31:0] rd_term  = term_cmp ? rd_cm : rd_tm;

  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0;
    if (hit_state || hit_pre) begin
      rdata = rd_state;
    end else if (hit_pins) begin
      rdata = rd_pins;
    end else if (hit_cfg) begin
      rdata = rd_cfg;
    end else if (hit_term) begin
      rdata = rd_term;
    end
  end

  // Byte-merged next values for partial writes
  wire [31:0]               pre_w   = merge(rd_state, dat_i, sel_i);
  wire [pom_pkg::CFG_W-1:0] cfg_d   = pom_pkg::CFG_W'(merge(rd_cfg, dat_i, sel_i));
  wire [NLIT-1:0]           tmask_d = NLIT'(merge(rd_tm, dat_i, sel_i));
  wire [NLIT-1:0]           cmask_d = NLIT'(merge(rd_cm, dat_i, sel_i));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end
  assign ack_o = ack_q;

  // Read data holds until the next accepted request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (req) begin
      dat_o <= rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NC; c++) begin
        cfg_q[c] <= pom_pkg::CFG_RESET;
      end
    end else if (wr_cfg) begin
      cfg_q[cfg_idx] <= cfg_d;
    end
  end

  // All literals connected: every term false until programmed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int t = 0; t < NT; t++) begin
        tmask_q[t] <= '1;
      end
    end else if (wr_tmask) begin
      tmask_q[term_idx] <= tmask_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int t = 0; t < NT; t++) begin
        cmask_q[t] <= '1;
      end
    end else if (wr_cmask) begin
      cmask_q[term_idx] <= cmask_d;
    end
  end

  // Value captured on a device clock edge
  wire [NC-1:0] q_clk_d = sp ? {NC{1'b1}} : sum;

  // Clear outranks preload so a held clear term is never overridden
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_q <= '0;
    end else if (ar) begin
      q_q <= '0;
    end else if (wr_pre) begin
      q_q <= pre_w[NC-1:0];
    end else if (pclk_rise) begin
      q_q <= q_clk_d;
    end
  end
endmodule

// >>> logic/pom_pkg.sv
// Constants for the programmable output macrocell array
package pom_pkg;
  localparam int NUM_CELL     = 10;
  localparam int NUM_IN       = 8;
  localparam int WIDE_CELLS   = 2;
  localparam int WIDE_TERMS   = 10;
  localparam int NARROW_TERMS = 8;
  localparam int LOGIC_TERMS  = WIDE_CELLS * WIDE_TERMS + (NUM_CELL - WIDE_CELLS) * NARROW_TERMS;
  localparam int OE_BASE      = LOGIC_TERMS;
  localparam int AR_IDX       = OE_BASE + NUM_CELL;
  localparam int SP_IDX       = AR_IDX + 1;
  localparam int NUM_TERMS    = SP_IDX + 1;
  localparam int ADR_W        = 12;

  // Byte addresses on the register bus
  localparam logic [11:0] ADR_STATE     = 12'h000;
  localparam logic [11:0] ADR_PRELOAD   = 12'h004;
  localparam logic [11:0] ADR_PINS      = 12'h008;
  localparam logic [5:0]  CFG_REGION    = 6'h01;
  localparam logic [1:0]  TERM_REGION   = 2'h1;
  localparam int          PINS_IN_LSB   = 16;

  // Cell configuration fields
  localparam int          CFG_W         = 4;
  localparam int          CFG_POL_BIT   = 0;
  localparam int          CFG_MODE_BIT  = 1;
  localparam int          CFG_OE_LSB    = 2;
  localparam logic        POL_TRUE      = 1'b1;
  localparam logic        MODE_COMB     = 1'b1;
  localparam logic [1:0]  OE_TERM       = 2'h0;
  localparam logic [1:0]  OE_ON         = 2'h1;
  localparam logic [1:0]  OE_OFF        = 2'h2;
  localparam logic [3:0]  CFG_RESET     = 4'h1;
endpackage
